// ==== src/pbt_pkg.sv ====
package pbt_pkg;
  // register offsets
  localparam logic [7:0] calib_config_one_addr = 8'hd9;
  localparam logic [7:0] mult_sel_addr         = 8'he0;
  localparam logic [7:0] control_addr          = 8'he1;
  localparam logic [7:0] status_addr           = 8'he2;
  localparam logic [7:0] mask_addr             = 8'he3;
  localparam logic [7:0] base_lo_addr          = 8'he4;
  localparam logic [7:0] base_hi_addr          = 8'he5;
  localparam logic [7:0] entry_lo_addr         = 8'he6;
  localparam logic [7:0] entry_hi_addr         = 8'he7;
  localparam logic [7:0] exit_lo_addr          = 8'he8;
  localparam logic [7:0] exit_hi_addr          = 8'he9;
  localparam logic [7:0] meas_lo_addr          = 8'hea;
  localparam logic [7:0] meas_hi_addr          = 8'heb;
  localparam logic [7:0] offset_base_addr      = 8'hec;
  // field positions in calib_config_one
  localparam int auto_thr_bit     = 7;
  localparam int autodec_bit      = 6;
  localparam int auto_base_bit    = 3;
  localparam int win_lsb          = 0;
  localparam logic [7:0] cfg_writable_mask = 8'hcf;
  // status and mask bits
  localparam int lowered_bit      = 0;
  localparam int trimmed_bit      = 1;
  // control bits
  localparam int prox_mode_bit    = 0;
  // widths
  localparam int sample_w         = 14;
  localparam int thr_w            = 16;
  localparam int chan_n           = 4;
  localparam int chan_w           = 2;
  localparam int acc_w            = 21;
  // reset values
  localparam logic [7:0]  calib_config_one_rst = 8'h0c;
  localparam logic [3:0]  mult_sel_rst         = 4'h0;
  localparam logic [13:0] base_rst             = 14'h3fff;
  localparam logic [15:0] thr_rst              = 16'hffff;
  localparam logic [7:0]  offset_rst           = 8'h00;
  localparam logic [4:0]  mult_bias            = 5'h04;
endpackage

// ==== src/pbt_avg_if.sv ====
`timescale 1ns/1ns
// links the tracker to its window averager
interface pbt_avg_if;
  logic                          sample_valid;
  logic [pbt_pkg::sample_w-1:0]  sample_data;
  logic [2:0]                    window_sel;
  logic                          avg_done;
  logic [pbt_pkg::sample_w-1:0]  avg_value;
  modport tracker (output sample_valid, output sample_data, output window_sel,
                   input avg_done, input avg_value);
  modport averager (input sample_valid, input sample_data, input window_sel,
                    output avg_done, output avg_value);
endinterface

// ==== src/pbt_window_avg.sv ====
`timescale 1ns/1ns
module pbt_window_avg (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // averager side
  pbt_avg_if.averager av
);
  logic [pbt_pkg::acc_w-1:0] acc;
  logic [7:0]                cnt;
  logic                      skip;
  logic [7:0]                target;
  logic [7:0]                next_cnt;
  logic [pbt_pkg::acc_w-1:0] next_acc;
  logic                      window_end;
  logic [pbt_pkg::acc_w-1:0] shifted;

  // window length and end-of-window detect
  assign skip       = (av.window_sel == 3'h0);
  assign target     = 8'h01 << av.window_sel;
  assign next_cnt   = cnt + 8'h01;
  assign next_acc   = acc + {{(pbt_pkg::acc_w-pbt_pkg::sample_w){1'b0}}, av.sample_data};
  assign window_end = av.sample_valid && (skip || next_cnt >= target);
  assign shifted    = next_acc >> av.window_sel;

  // accumulate, publish only at the end of each window
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc          <= '0;
      cnt          <= 8'h00;
      av.avg_done  <= 1'b0;
      av.avg_value <= '0;
    end else begin
      av.avg_done <= window_end;
      if (window_end) begin
        acc          <= '0;
        cnt          <= 8'h00;
        av.avg_value <= skip ? av.sample_data : shifted[pbt_pkg::sample_w-1:0];
      end else if (av.sample_valid) begin
        acc <= next_acc;
        cnt <= next_cnt;
      end
    end
  end
endmodule // pbt_window_avg

// ==== src/pbt_baseline_tracker.sv ====
`timescale 1ns/1ns
module pbt_baseline_tracker (
  // clock and reset
  input  wire logic                                    core_clk,
  input  wire logic                                    rst,
  // register port
  input  wire logic [7:0]                              reg_addr,
  input  wire logic [7:0]                              reg_wdata,
  input  wire logic                                    reg_wr,
  input  wire logic                                    reg_rd,
  output logic      [7:0]                              reg_rdata,
  // proximity samples
  input  wire logic                                    sample_valid,
  input  wire logic [pbt_pkg::sample_w-1:0]            sample_data,
  input  wire logic [pbt_pkg::chan_w-1:0]              sample_chan,
  // results to the engine
  output logic      [pbt_pkg::sample_w-1:0]            stored_prox_baseline,
  output logic      [pbt_pkg::thr_w-1:0]               gesture_entry_threshold,
  output logic      [pbt_pkg::thr_w-1:0]               gesture_exit_threshold,
  output logic      [8*pbt_pkg::chan_n-1:0]            offset_flat,
  // interrupt
  output logic                                         irq
);
  pbt_avg_if avg_bus ();

  logic [7:0]                   calib_config_one;
  logic [3:0]                   threshold_multiplier_sel;
  logic [7:0]                   control;
  logic [1:0]                   status;
  logic [1:0]                   mask;
  logic [7:0]                   offset_reg [pbt_pkg::chan_n];
  logic [pbt_pkg::sample_w-1:0] measured_baseline_avg;

  logic                         auto_threshold_enable;
  logic                         offset_autodec_enable;
  logic                         auto_baseline_enable;
  logic [2:0]                   baseline_window_sel;
  logic                         prox_mode;

  // configuration fields
  assign auto_threshold_enable = calib_config_one[pbt_pkg::auto_thr_bit];
  assign offset_autodec_enable = calib_config_one[pbt_pkg::autodec_bit];
  assign auto_baseline_enable  = calib_config_one[pbt_pkg::auto_base_bit];
  assign baseline_window_sel   = calib_config_one[pbt_pkg::win_lsb +: 3];
  assign prox_mode             = control[pbt_pkg::prox_mode_bit];

  // averager feed
  assign avg_bus.sample_valid = sample_valid && prox_mode;
  assign avg_bus.sample_data  = sample_data;
  assign avg_bus.window_sel   = baseline_window_sel;

  pbt_window_avg u_avg (
    .core_clk (core_clk),
    .rst      (rst),
    .av       (avg_bus.averager)
  );

  // write decode
  logic wr_cfg;
  logic wr_mult;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic wr_base_lo;
  logic wr_base_hi;
  logic wr_entry_lo;
  logic wr_entry_hi;
  logic wr_exit_lo;
  logic wr_exit_hi;
  assign wr_cfg      = reg_wr && (reg_addr == pbt_pkg::calib_config_one_addr);
  assign wr_mult     = reg_wr && (reg_addr == pbt_pkg::mult_sel_addr);
  assign wr_ctrl     = reg_wr && (reg_addr == pbt_pkg::control_addr);
  assign wr_status   = reg_wr && (reg_addr == pbt_pkg::status_addr);
  assign wr_mask     = reg_wr && (reg_addr == pbt_pkg::mask_addr);
  assign wr_base_lo  = reg_wr && (reg_addr == pbt_pkg::base_lo_addr);
  assign wr_base_hi  = reg_wr && (reg_addr == pbt_pkg::base_hi_addr);
  assign wr_entry_lo = reg_wr && (reg_addr == pbt_pkg::entry_lo_addr);
  assign wr_entry_hi = reg_wr && (reg_addr == pbt_pkg::entry_hi_addr);
  assign wr_exit_lo  = reg_wr && (reg_addr == pbt_pkg::exit_lo_addr);
  assign wr_exit_hi  = reg_wr && (reg_addr == pbt_pkg::exit_hi_addr);

  // baseline lowering decision
  logic                         lower_now;
  logic [pbt_pkg::sample_w-1:0] next_baseline;
  assign lower_now = avg_bus.avg_done && auto_baseline_enable
                     && (avg_bus.avg_value < stored_prox_baseline);
  always_comb begin
    next_baseline = stored_prox_baseline;
    if (lower_now) begin
      next_baseline = avg_bus.avg_value;
    end else if (wr_base_lo) begin
      next_baseline = {stored_prox_baseline[13:8], reg_wdata};
    end else if (wr_base_hi) begin
      next_baseline = {reg_wdata[5:0], stored_prox_baseline[7:0]};
    end
  end

  // threshold from baseline times (sel + 4) / 4, saturated
  logic [4:0]  mult_factor;
  logic [18:0] thr_prod;
  logic [16:0] thr_quot;
  logic [15:0] thr_sat;
  logic        base_changes;
  assign mult_factor  = {1'b0, threshold_multiplier_sel} + pbt_pkg::mult_bias;
  assign thr_prod     = {5'h00, next_baseline} * {14'h0000, mult_factor};
  assign thr_quot     = thr_prod[18:2];
  assign thr_sat      = thr_quot[16] ? 16'hffff : thr_quot[15:0];
  assign base_changes = (next_baseline != stored_prox_baseline);
  logic        thr_follow;
  assign thr_follow   = auto_threshold_enable && base_changes;

  // zero-result offset trimming
  logic [pbt_pkg::chan_n-1:0] dec_hit;
  logic                       trim_event;
  genvar gi;
  generate
    for (gi = 0; gi < pbt_pkg::chan_n; gi++) begin : g_off
      logic wr_off;
      assign wr_off = reg_wr
                      && (reg_addr == pbt_pkg::offset_base_addr + 8'(gi));
      assign dec_hit[gi] = sample_valid && prox_mode && offset_autodec_enable
                           && (sample_data == '0)
                           && (sample_chan == pbt_pkg::chan_w'(gi))
                           && (offset_reg[gi] != 8'h00);
      // software write wins over a trim in the same cycle
      always_ff @(posedge core_clk) begin
        if (rst) begin
          offset_reg[gi] <= pbt_pkg::offset_rst;
        end else if (wr_off) begin
          offset_reg[gi] <= reg_wdata;
        end else if (dec_hit[gi]) begin
          offset_reg[gi] <= offset_reg[gi] - 8'h01;
        end
      end
      assign offset_flat[8*gi +: 8] = offset_reg[gi];
    end
  endgenerate
  assign trim_event = |dec_hit;

  // configuration registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      calib_config_one         <= pbt_pkg::calib_config_one_rst;
      threshold_multiplier_sel <= pbt_pkg::mult_sel_rst;
      control                  <= 8'h00;
      mask                     <= 2'b00;
    end else begin
      if (wr_cfg) begin
        calib_config_one <= reg_wdata & pbt_pkg::cfg_writable_mask;
      end
      if (wr_mult) begin
        threshold_multiplier_sel <= reg_wdata[3:0];
      end
      if (wr_ctrl) begin
        control <= {7'h00, reg_wdata[pbt_pkg::prox_mode_bit]};
      end
      if (wr_mask) begin
        mask <= reg_wdata[1:0];
      end
    end
  end

  // stored baseline
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stored_prox_baseline <= pbt_pkg::base_rst;
    end else begin
      stored_prox_baseline <= next_baseline;
    end
  end

  // last measured average, kept for software
  always_ff @(posedge core_clk) begin
    if (rst) begin
      measured_baseline_avg <= '0;
    end else if (avg_bus.avg_done) begin
      measured_baseline_avg <= avg_bus.avg_value;
    end
  end

  // gesture thresholds: hardware follow wins over a software write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gesture_entry_threshold <= pbt_pkg::thr_rst;
      gesture_exit_threshold  <= pbt_pkg::thr_rst;
    end else if (thr_follow) begin
      gesture_entry_threshold <= thr_sat;
      gesture_exit_threshold  <= thr_sat;
    end else begin
      if (wr_entry_lo) begin
        gesture_entry_threshold[7:0] <= reg_wdata;
      end
      if (wr_entry_hi) begin
        gesture_entry_threshold[15:8] <= reg_wdata;
      end
      if (wr_exit_lo) begin
        gesture_exit_threshold[7:0] <= reg_wdata;
      end
      if (wr_exit_hi) begin
        gesture_exit_threshold[15:8] <= reg_wdata;
      end
    end
  end

  // sticky status, write one to clear, a new event wins
  logic [1:0] set_bits;
  logic [1:0] clr_bits;
  logic [1:0] next_status;
  assign set_bits = {trim_event, lower_now};
  assign clr_bits = wr_status ? reg_wdata[1:0] : 2'b00;
  assign next_status = (status & ~clr_bits) | set_bits;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status <= 2'b00;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & mask);
    end
  end

  // read selection
  logic [7:0] rd_mux;
  logic [7:0] off_rd;
  logic       off_hit;
  logic [7:0] off_idx;
  assign off_idx = reg_addr - pbt_pkg::offset_base_addr;
  assign off_hit = (reg_addr >= pbt_pkg::offset_base_addr)
                   && (off_idx < 8'(pbt_pkg::chan_n));
  assign off_rd  = offset_reg[off_idx[pbt_pkg::chan_w-1:0]];
  always_comb begin
    if (reg_addr == pbt_pkg::calib_config_one_addr) begin
      rd_mux = calib_config_one & pbt_pkg::cfg_writable_mask;
    end else if (reg_addr == pbt_pkg::mult_sel_addr) begin
      rd_mux = {4'h0, threshold_multiplier_sel};
    end else if (reg_addr == pbt_pkg::control_addr) begin
      rd_mux = control;
    end else if (reg_addr == pbt_pkg::status_addr) begin
      rd_mux = {6'h00, status};
    end else if (reg_addr == pbt_pkg::mask_addr) begin
      rd_mux = {6'h00, mask};
    end else if (reg_addr == pbt_pkg::base_lo_addr) begin
      rd_mux = stored_prox_baseline[7:0];
    end else if (reg_addr == pbt_pkg::base_hi_addr) begin
      rd_mux = {2'b00, stored_prox_baseline[13:8]};
    end else if (reg_addr == pbt_pkg::entry_lo_addr) begin
      rd_mux = gesture_entry_threshold[7:0];
    end else if (reg_addr == pbt_pkg::entry_hi_addr) begin
      rd_mux = gesture_entry_threshold[15:8];
    end else if (reg_addr == pbt_pkg::exit_lo_addr) begin
      rd_mux = gesture_exit_threshold[7:0];
    end else if (reg_addr == pbt_pkg::exit_hi_addr) begin
      rd_mux = gesture_exit_threshold[15:8];
    end else if (reg_addr == pbt_pkg::meas_lo_addr) begin
      rd_mux = measured_baseline_avg[7:0];
    end else if (reg_addr == pbt_pkg::meas_hi_addr) begin
      rd_mux = {2'b00, measured_baseline_avg[13:8]};
    end else if (off_hit) begin
      rd_mux = off_rd;
    end else begin
      rd_mux = 8'h00;                                                   // unmapped reads zero
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end
endmodule // pbt_baseline_tracker

// ==== sim/pbt_chk_assertions.sv ====
`timescale 1ns/1ns
// watches the tracker's ports and checks baseline, threshold, trim and bus behaviour
module pbt_chk (
  // clock and reset
  input wire logic                         core_clk,
  input wire logic                         rst,
  // register port
  input wire logic [7:0]                   reg_addr,
  input wire logic [7:0]                   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [7:0]                   reg_rdata,
  // proximity samples
  input wire logic                         sample_valid,
  input wire logic [pbt_pkg::sample_w-1:0] sample_data,
  input wire logic [pbt_pkg::chan_w-1:0]   sample_chan,
  // results and interrupt
  input wire logic [pbt_pkg::sample_w-1:0] stored_prox_baseline,
  input wire logic [pbt_pkg::thr_w-1:0]    gesture_entry_threshold,
  input wire logic [pbt_pkg::thr_w-1:0]    gesture_exit_threshold,
  input wire logic [8*pbt_pkg::chan_n-1:0] offset_flat,
  input wire logic                         irq
);
  logic [7:0] cfg_sh;
  logic [7:0] mult_sh;
  logic [7:0] mask_sh;
  logic       ctl_sh;
  logic       p_trim;
  logic [1:0] p_chan;
  logic [7:0] p_off;
  // bus decodes, trim condition and expected automatic threshold
  wire        base_wr = reg_wr && reg_addr[7:1] == 7'h72;
  wire        off_wr  = reg_wr && reg_addr[7:2] == 6'h3b;
  wire        trim_ok = sample_valid && sample_data == '0 && cfg_sh[6] && ctl_sh && !off_wr;
  wire [7:0]  cur_off = offset_flat[8*sample_chan +: 8];
  wire [7:0]  sel_off = offset_flat[8*p_chan +: 8];
  wire [18:0] prod    = stored_prox_baseline * (mult_sh[3:0] + 5'h04);
  wire [15:0] exp_thr = prod[18] ? 16'hffff : prod[17:2]; // saturates at full scale
  // shadows of the software settings and the last sample's trim state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_sh <= pbt_pkg::calib_config_one_rst;
      mult_sh <= 8'h00;
      mask_sh <= 8'h00;
      ctl_sh <= 1'b0;
      p_trim <= 1'b0;
      p_chan <= 2'h0;
      p_off <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == pbt_pkg::calib_config_one_addr) cfg_sh <= reg_wdata & 8'hcf;
      if (reg_wr && reg_addr == pbt_pkg::mult_sel_addr) mult_sh <= reg_wdata & 8'h0f;
      if (reg_wr && reg_addr == pbt_pkg::mask_addr) mask_sh <= reg_wdata;
      if (reg_wr && reg_addr == pbt_pkg::control_addr) ctl_sh <= reg_wdata[0];
      p_trim <= trim_ok;
      p_chan <= sample_chan;
      p_off <= cur_off;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_base_only_down: assert property (
    stored_prox_baseline != $past(stored_prox_baseline) && !$past(base_wr) |->
    stored_prox_baseline < $past(stored_prox_baseline) && $past(cfg_sh[3]))
    else $error("baseline moved without a lower tracked average");
  chk_entry_follow: assert property (
    stored_prox_baseline < $past(stored_prox_baseline) && !$past(base_wr) && cfg_sh[7]
    |-> gesture_entry_threshold == exp_thr) else $error("entry threshold not baseline times factor");
  chk_exit_follow: assert property (
    stored_prox_baseline < $past(stored_prox_baseline) && !$past(base_wr) && cfg_sh[7]
    |-> gesture_exit_threshold == gesture_entry_threshold) else $error("exit threshold differs");
  chk_lower_irq: assert property (
    stored_prox_baseline < $past(stored_prox_baseline) && !$past(base_wr) && mask_sh[0]
    |-> irq) else $error("baseline lowered without interrupt");
  chk_trim_step: assert property (
    p_trim && p_off != 8'h00 |-> sel_off == p_off - 8'h01) else $error("offset not decremented");
  chk_trim_irq: assert property (
    p_trim && p_off != 8'h00 && mask_sh[1] |-> irq) else $error("trim without interrupt");
  chk_offset_cause: assert property (
    offset_flat != $past(offset_flat) && !$past(off_wr) |-> p_trim)
    else $error("offset changed without a zero sample");
  chk_cfg_read: assert property (
    $past(reg_rd && reg_addr == pbt_pkg::calib_config_one_addr) |-> reg_rdata == $past(cfg_sh))
    else $error("config read back wrong");
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read cycle");
  chk_irq_masked: assert property (
    mask_sh[1:0] == 2'b00 && $past(mask_sh[1:0]) == 2'b00 |-> !irq)
    else $error("interrupt while masked");
endmodule // pbt_chk

bind pbt_baseline_tracker pbt_chk chk_u (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
  .sample_data(sample_data), .sample_chan(sample_chan),
  .stored_prox_baseline(stored_prox_baseline), .gesture_entry_threshold(gesture_entry_threshold),
  .gesture_exit_threshold(gesture_exit_threshold), .offset_flat(offset_flat), .irq(irq));

// ==== sim/tb.sv ====
`timescale 1ns/1ns
// self-checking bench for the baseline tracker
module tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        sample_valid = 1'b0;
  logic [13:0] sample_data = 14'h0000;
  logic [1:0]  sample_chan = 2'h0;
  logic [13:0] base;
  logic [15:0] entry;
  logic [15:0] exits;
  logic [31:0] offs;
  logic        irq;
  int          error_cnt = 0;
  int          checks_done = 0;
  // clock at 100 MHz
  always #5 core_clk = ~core_clk;
  pbt_baseline_tracker dut_u (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .sample_data(sample_data), .sample_chan(sample_chan), .stored_prox_baseline(base),
    .gesture_entry_threshold(entry), .gesture_exit_threshold(exits), .offset_flat(offs),
    .irq(irq));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one write, then an idle cycle so strobes never toggle twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    // read data stand only in the cycle after the strobe: look mid-cycle
    @(negedge core_clk);
    chk(nm, reg_rdata, exp);
    @(posedge core_clk);
  endtask
  task automatic smp(input int v, input logic [1:0] c);
    sample_data <= v[13:0];
    sample_chan <= c;
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask
  task automatic t_reset();
    rchk("cfg", pbt_pkg::calib_config_one_addr, 8'h0c);
    chk("base", base, 14'h3fff);
    chk("entry", entry, 16'hffff);
    chk("offs", offs, 32'h0);
    chk("irq", irq, 1'b0);
  endtask
  task automatic t_reserved();
    wr(pbt_pkg::calib_config_one_addr, 8'hff);
    rchk("cfg", pbt_pkg::calib_config_one_addr, 8'hcf);
    rchk("unmapped", 8'h10, 8'h00);
    wr(pbt_pkg::calib_config_one_addr, 8'h0c);
  endtask
  // windows of 128, 8, 2 and 1 samples, each lowering the baseline
  task automatic t_window();
    int sels[4] = '{7, 3, 1, 0};
    int mults[4] = '{15, 2, 1, 0};
    int vals[4] = '{16000, 9000, 5000, 1000};
    int n, sum, avg, thr;
    logic [13:0] prev;
    wr(pbt_pkg::control_addr, 8'h01);
    wr(pbt_pkg::mask_addr, 8'h01);
    for (int k = 0; k < 4; k++) begin
      n = 1 << sels[k];
      sum = 0;
      prev = base;
      wr(pbt_pkg::mult_sel_addr, mults[k][7:0]);
      wr(pbt_pkg::calib_config_one_addr, 8'h88 | sels[k][7:0]);
      for (int i = 0; i < n; i++) begin
        smp(vals[k] + i, i[1:0]);
        sum += vals[k] + i;
        if (i == n - 2) chk("mid", base, prev);
      end
      avg = sum >> sels[k];
      thr = avg * (mults[k] + 4) / 4;
      if (thr > 65535) thr = 65535;
      settle();
      chk("base", base, avg);
      chk("entry", entry, thr);
      chk("exit", exits, thr);
      chk("irq", irq, 1'b1);
      rchk("status", pbt_pkg::status_addr, 8'h01);
      wr(pbt_pkg::status_addr, 8'h01);
      chk("irq", irq, 1'b0);
    end
  endtask
  task automatic t_hold();
    wr(pbt_pkg::calib_config_one_addr, 8'h89);
    smp(1100, 2'h0);
    smp(1100, 2'h0);
    settle();
    chk("base", base, 14'd1000);
    chk("irq", irq, 1'b0);
    wr(pbt_pkg::calib_config_one_addr, 8'h80);
    smp(10, 2'h0);
    settle();
    chk("base", base, 14'd1000);
    wr(pbt_pkg::calib_config_one_addr, 8'h08);
    smp(500, 2'h1);
    settle();
    chk("base", base, 14'd500);
    chk("entry", entry, 16'd1000);
    wr(pbt_pkg::status_addr, 8'h01);
  endtask
  task automatic t_trim();
    wr(pbt_pkg::calib_config_one_addr, 8'h40);
    wr(pbt_pkg::mask_addr, 8'h02);
    wr(pbt_pkg::offset_base_addr + 8'h02, 8'h02);
    smp(0, 2'h2);
    chk("offs", offs, 32'h0001_0000);
    chk("irq", irq, 1'b1);
    rchk("status", pbt_pkg::status_addr, 8'h02);
    wr(pbt_pkg::status_addr, 8'h02);
    smp(0, 2'h2);
    wr(pbt_pkg::status_addr, 8'h02);
    smp(0, 2'h2);
    chk("offs", offs, 32'h0);
    chk("irq", irq, 1'b0);
    wr(pbt_pkg::offset_base_addr + 8'h01, 8'h03);
    wr(pbt_pkg::control_addr, 8'h00);
    smp(0, 2'h1);
    chk("offs", offs, 32'h0000_0300);
    wr(pbt_pkg::control_addr, 8'h01);
    wr(pbt_pkg::calib_config_one_addr, 8'h00);
    smp(0, 2'h1);
    chk("offs", offs, 32'h0000_0300);
    wr(pbt_pkg::calib_config_one_addr, 8'h40);
    smp(0, 2'h1);
    chk("offs", offs, 32'h0000_0200);
    chk("irq", irq, 1'b1);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence, with a second reset in mid-run
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_reserved();
    t_window();
    t_hold();
    t_trim();
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    summarize();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end
endmodule // tb
